//--- common/gcr_pkg.sv
// Operation
// - constant build fixes sizes and tables and drops the register port
// - constant build: reset only by reset input, run only by clock gate
// - master uses 32-bit address and data read/write transfers; we serve
// - every write and read completes with a 2-bit response code
// - control at offset zero: run bit 0, commit bit 1, resets to zero
// - bits 4, 5 and the throughput counters exist only in debug builds
// - writing one to control bit 30 requests a frame-aligned core reset
// - writing one to control bit 31 holds the core in software reset
// - status: frame begun bit 0, frame done bit 1, error summary bit 16
// - error bits 0-3: line short, line long, frame early, frame late
// - interrupt mask bits 16 to 0 pair with status bits, reset zero
// - version word: revision, patch, version revision, minor, major
// - read-only frame counter, reset zero, debug builds only
// - read-only line and pixel counters, reset zero, debug builds only
// - double-buffered dimensions: pixels 12-0, lines 28-16, reset param
// - double-buffered bank-swap register, reset zero, selects lut bank
// - table port write stores bits 15-0 at table address bits 31-16
// - status and error bits stick until a one is written to them
// - interrupt is OR of status bits ANDed with matching mask bits
// - shadow values move to active set at frame end when commit is set
// - frame-aligned reset bit clears itself in the cycle the reset is issued
package gcr_pkg;
	localparam logic [31:0] GCR_OFS_CTRL = 32'h0000_0000;
	localparam logic [31:0] GCR_OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] GCR_OFS_ERROR = 32'h0000_0008;
	localparam logic [31:0] GCR_OFS_MASK = 32'h0000_000c;
	localparam logic [31:0] GCR_OFS_VERSION = 32'h0000_0010;
	localparam logic [31:0] GCR_OFS_FRAMES = 32'h0000_0014;
	localparam logic [31:0] GCR_OFS_LINES = 32'h0000_0018;
	localparam logic [31:0] GCR_OFS_PIXELS = 32'h0000_001c;
	localparam logic [31:0] GCR_OFS_DIMS = 32'h0000_0020;
	localparam logic [31:0] GCR_OFS_SWAP = 32'h0000_0100;
	localparam logic [31:0] GCR_OFS_LUTWR = 32'h0000_0104;

	localparam int GCR_CTRL_RUN = 0;
	localparam int GCR_CTRL_COMMIT = 1;
	localparam int GCR_CTRL_BYPASS = 4;
	localparam int GCR_CTRL_TPAT = 5;
	localparam int GCR_CTRL_FSR = 30;
	localparam int GCR_CTRL_SWR = 31;

	localparam int GCR_ST_BEGUN = 0;
	localparam int GCR_ST_DONE = 1;
	localparam int GCR_ST_ERR = 16;
	localparam int GCR_ST_W = 17;

	localparam int GCR_ER_LINE_SHORT = 0;
	localparam int GCR_ER_LINE_LONG = 1;
	localparam int GCR_ER_FRAME_EARLY = 2;
	localparam int GCR_ER_FRAME_LATE = 3;
	localparam int GCR_ER_W = 4;

	localparam int GCR_DIM_W = 13;
	localparam int GCR_DIM_PIX_LSB = 0;
	localparam int GCR_DIM_LIN_LSB = 16;
	localparam int GCR_LUT_DAT_LSB = 0;
	localparam int GCR_LUT_ADR_LSB = 16;
	localparam int GCR_LUT_W = 16;

	localparam logic [1:0] GCR_RESP_OKAY = 2'h0;
	localparam logic [31:0] GCR_ZERO = 32'h0000_0000;

	// stream-side events, one cycle each, already qualified by transfer
	typedef struct packed {
		logic xfer;
		logic sof;
		logic eol;
	} gcr_strm_t;

	typedef struct packed {
		logic wr;
		logic [GCR_LUT_W-1:0] addr;
		logic [GCR_LUT_W-1:0] data;
	} gcr_lutwr_t;
endpackage : gcr_pkg

//--- verilog/gcr_counter.sv
`timescale 1ns/100ps
module gcr_counter
	import gcr_pkg::*;
#(
	parameter int W = 32
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic inc,
	output logic [W-1:0] cnt
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} gcr_cnt_st_t;

	gcr_cnt_st_t q, d;

	always_comb begin
		d = q;
		if (sys_rst || clr) begin
			d.cnt = '0;
		end else if (inc) begin
			// wraps silently; software takes differences
			d.cnt = q.cnt + W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign cnt = q.cnt;
endmodule : gcr_counter

//--- verilog/gcr_regbank.sv
`timescale 1ns/100ps
module gcr_regbank
	import gcr_pkg::*;
#(
	parameter bit HAS_LITE = 1'b1,
	parameter bit HAS_DEBUG = 1'b1,
	parameter logic [31:0] DIM_RESET = 32'h0000_0000,
	// arbitrary value, not tied to any real part
	parameter logic [31:0] VERSION_ID = 32'h0001_0200
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic core_clock_gate,
	input wire logic s_axi_lite_awvalid,
	output logic s_axi_lite_awready,
	input wire logic [31:0] s_axi_lite_awaddr,
	input wire logic s_axi_lite_wvalid,
	output logic s_axi_lite_wready,
	input wire logic [31:0] s_axi_lite_wdata,
	output logic [1:0] s_axi_lite_bresp,
	output logic s_axi_lite_bvalid,
	input wire logic s_axi_lite_bready,
	input wire logic s_axi_lite_arvalid,
	output logic s_axi_lite_arready,
	input wire logic [31:0] s_axi_lite_araddr,
	output logic s_axi_lite_rvalid,
	input wire logic s_axi_lite_rready,
	output logic [31:0] s_axi_lite_rdata,
	output logic [1:0] s_axi_lite_rresp,
	input wire gcr_strm_t strm,
	output logic core_run,
	output logic bypass_on,
	output logic pattern_on,
	output logic core_reset,
	output logic [31:0] active_dims,
	output logic [31:0] active_swap,
	output gcr_lutwr_t lut_wr,
	output logic irq
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic run;
		logic commit;
		logic bypass;
		logic tpat;
		logic fsr;
		logic swr;
		logic [GCR_ST_W-1:0] sts;
		logic [GCR_ER_W-1:0] err;
		logic [GCR_ST_W-1:0] mask;
		logic [31:0] dim_sh;
		logic [31:0] dim_act;
		logic [31:0] swap_sh;
		logic [31:0] swap_act;
		gcr_lutwr_t lut;
		logic in_frame;
		logic [GCR_DIM_W-1:0] pix_cnt;
		logic [GCR_DIM_W-1:0] line_cnt;
		logic core_rst;
		logic irq;
	} gcr_st_t;

	gcr_st_t q, d;
	logic [31:0] frames, lines, pixels;
	logic live, fr_end, wr_go, rd_go;
	gcr_strm_t ev;
	logic [GCR_DIM_W-1:0] px_n, ln_n, dim_px, dim_ln;
	logic [GCR_ST_W-1:0] st_set, st_clr;
	logic [GCR_ER_W-1:0] er_set, er_clr;
	logic [31:0] ctrl_rd;

	// counters exist only in debug builds; otherwise they read zero
	gcr_counter #(.W(32)) u_frames (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clr(q.core_rst),
		.inc(HAS_DEBUG && fr_end && core_clock_gate),
		.cnt(frames)
	);
	gcr_counter #(.W(32)) u_lines (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clr(q.core_rst),
		.inc(HAS_DEBUG && ev.eol && core_clock_gate),
		.cnt(lines)
	);
	gcr_counter #(.W(32)) u_pixels (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clr(q.core_rst),
		.inc(HAS_DEBUG && ev.xfer && core_clock_gate),
		.cnt(pixels)
	);

	always_comb begin
		ctrl_rd = GCR_ZERO;
		ctrl_rd[GCR_CTRL_RUN] = q.run;
		ctrl_rd[GCR_CTRL_COMMIT] = q.commit;
		ctrl_rd[GCR_CTRL_BYPASS] = q.bypass;
		ctrl_rd[GCR_CTRL_TPAT] = q.tpat;
		ctrl_rd[GCR_CTRL_FSR] = q.fsr;
		ctrl_rd[GCR_CTRL_SWR] = q.swr;
	end

	always_comb begin
		d = q;
		st_set = '0;
		st_clr = '0;
		er_set = '0;
		er_clr = '0;
		fr_end = 1'b0;
		dim_px = q.dim_act[GCR_DIM_PIX_LSB +: GCR_DIM_W];
		dim_ln = q.dim_act[GCR_DIM_LIN_LSB +: GCR_DIM_W];
		px_n = q.pix_cnt + GCR_DIM_W'(1);
		ln_n = q.line_cnt + GCR_DIM_W'(1);
		// stream activity is ignored while halted or held in reset
		live = q.run && !q.core_rst;
		ev = live ? strm : '0;
		wr_go = q.awready && q.wready;
		rd_go = q.arready;
		d.lut.wr = 1'b0;

		if (HAS_LITE) begin
			// one write and one read at a time; write ready pulses once both halves wait
			d.awready = s_axi_lite_awvalid && s_axi_lite_wvalid &&
				!q.awready && !q.bvalid;
			d.wready = d.awready;
			d.arready = s_axi_lite_arvalid && !q.arready && !q.rvalid;
			if (q.bvalid && s_axi_lite_bready) begin
				d.bvalid = 1'b0;
			end
			if (q.rvalid && s_axi_lite_rready) begin
				d.rvalid = 1'b0;
			end
			if (wr_go) begin
				d.bvalid = 1'b1;
				case (s_axi_lite_awaddr)
				GCR_OFS_CTRL: begin
					d.run = s_axi_lite_wdata[GCR_CTRL_RUN];
					d.commit = s_axi_lite_wdata[GCR_CTRL_COMMIT];
					d.bypass = HAS_DEBUG && s_axi_lite_wdata[GCR_CTRL_BYPASS];
					d.tpat = HAS_DEBUG && s_axi_lite_wdata[GCR_CTRL_TPAT];
					d.fsr = s_axi_lite_wdata[GCR_CTRL_FSR];
					d.swr = s_axi_lite_wdata[GCR_CTRL_SWR];
				end
				GCR_OFS_STATUS: st_clr = s_axi_lite_wdata[GCR_ST_W-1:0];
				GCR_OFS_ERROR: er_clr = s_axi_lite_wdata[GCR_ER_W-1:0];
				GCR_OFS_MASK: d.mask = s_axi_lite_wdata[GCR_ST_W-1:0];
				GCR_OFS_DIMS: d.dim_sh = s_axi_lite_wdata;
				GCR_OFS_SWAP: d.swap_sh = s_axi_lite_wdata;
				GCR_OFS_LUTWR: begin
					d.lut.wr = 1'b1;
					d.lut.addr = s_axi_lite_wdata[GCR_LUT_ADR_LSB +: GCR_LUT_W];
					d.lut.data = s_axi_lite_wdata[GCR_LUT_DAT_LSB +: GCR_LUT_W];
				end
				default: ;
				endcase
			end
			if (rd_go) begin
				d.rvalid = 1'b1;
				case (s_axi_lite_araddr)
				GCR_OFS_CTRL: d.rdata = ctrl_rd;
				GCR_OFS_STATUS: d.rdata = 32'(q.sts);
				GCR_OFS_ERROR: d.rdata = 32'(q.err);
				GCR_OFS_MASK: d.rdata = 32'(q.mask);
				GCR_OFS_VERSION: d.rdata = VERSION_ID;
				GCR_OFS_FRAMES: d.rdata = frames;
				GCR_OFS_LINES: d.rdata = lines;
				GCR_OFS_PIXELS: d.rdata = pixels;
				GCR_OFS_DIMS: d.rdata = q.dim_sh;
				GCR_OFS_SWAP: d.rdata = q.swap_sh;
				GCR_OFS_LUTWR: d.rdata = {q.lut.addr, q.lut.data};
				default: d.rdata = GCR_ZERO;
				endcase
			end
		end else begin
			// constant build: no bus answers, sizes fixed, always running
			d.run = 1'b1;
			d.dim_sh = DIM_RESET;
			d.dim_act = DIM_RESET;
		end

		// frame tracking and size checks against the active dimensions
		if (ev.xfer) begin
			if (ev.sof) begin
				st_set[GCR_ST_BEGUN] = 1'b1;
				if (q.in_frame && q.line_cnt < dim_ln) begin
					er_set[GCR_ER_FRAME_EARLY] = 1'b1;
				end
				d.in_frame = 1'b1;
				d.line_cnt = '0;
				// the sof pixel is the first pixel of its line
				d.pix_cnt = GCR_DIM_W'(1);
			end else if (q.in_frame && q.line_cnt >= dim_ln) begin
				er_set[GCR_ER_FRAME_LATE] = 1'b1;
			end
			if (ev.eol) begin
				if ((ev.sof ? GCR_DIM_W'(1) : px_n) < dim_px) begin
					er_set[GCR_ER_LINE_SHORT] = 1'b1;
				end
				if ((ev.sof ? GCR_DIM_W'(1) : px_n) > dim_px) begin
					er_set[GCR_ER_LINE_LONG] = 1'b1;
				end
				d.pix_cnt = '0;
				d.line_cnt = ev.sof ? GCR_DIM_W'(1) : ln_n;
				if ((ev.sof ? GCR_DIM_W'(1) : ln_n) == dim_ln) begin
					fr_end = 1'b1;
					d.in_frame = 1'b0;
					st_set[GCR_ST_DONE] = 1'b1;
				end
			end else if (!ev.sof) begin
				d.pix_cnt = px_n;
			end
		end
		st_set[GCR_ST_ERR] = |er_set;

		// set wins over a clear in the same cycle
		d.sts = (q.sts & ~st_clr) | st_set;
		d.err = (q.err & ~er_clr) | er_set;

		// commit only at a frame boundary to avoid tearing
		if (fr_end && q.commit) begin
			d.dim_act = q.dim_sh;
			d.swap_act = q.swap_sh;
		end

		// frame-aligned reset fires at frame end, or at once between frames
		d.core_rst = q.swr;
		if (q.fsr && (!q.in_frame || fr_end)) begin
			d.core_rst = 1'b1;
			d.fsr = 1'b0;
		end
		if (q.core_rst) begin
			d.in_frame = 1'b0;
			d.pix_cnt = '0;
			d.line_cnt = '0;
		end

		d.irq = |(q.sts & q.mask);

		// halted cycles keep all state; reset overrides the halt
		if (!core_clock_gate) begin
			d = q;
		end
		if (sys_rst) begin
			d = '0;
			d.dim_sh = DIM_RESET;
			d.dim_act = DIM_RESET;
			d.run = !HAS_LITE;
		end
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign s_axi_lite_awready = q.awready;
	assign s_axi_lite_wready = q.wready;
	assign s_axi_lite_bvalid = q.bvalid;
	assign s_axi_lite_bresp = GCR_RESP_OKAY;
	assign s_axi_lite_arready = q.arready;
	assign s_axi_lite_rvalid = q.rvalid;
	assign s_axi_lite_rdata = q.rdata;
	assign s_axi_lite_rresp = GCR_RESP_OKAY;
	assign core_run = q.run;
	assign bypass_on = q.bypass;
	assign pattern_on = q.tpat;
	assign core_reset = q.core_rst;
	assign active_dims = q.dim_act;
	assign active_swap = q.swap_act;
	assign lut_wr = q.lut;
	assign irq = q.irq;
endmodule : gcr_regbank

//--- test/gcr_properties.sv
`timescale 1ns/100ps
module gcr_properties
	import gcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic core_clock_gate,
	input wire logic s_axi_lite_awvalid,
	input wire logic s_axi_lite_wvalid,
	input wire logic s_axi_lite_awready,
	input wire logic s_axi_lite_wready,
	input wire logic s_axi_lite_bvalid,
	input wire logic s_axi_lite_bready,
	input wire logic [1:0] s_axi_lite_bresp,
	input wire logic s_axi_lite_arvalid,
	input wire logic s_axi_lite_arready,
	input wire logic s_axi_lite_rvalid,
	input wire logic s_axi_lite_rready,
	input wire logic [1:0] s_axi_lite_rresp
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	wire en = core_clock_gate;
	wire awr = s_axi_lite_awready;
	wire bv = s_axi_lite_bvalid;
	wire arr = s_axi_lite_arready;
	wire rv = s_axi_lite_rvalid;
	// a lone address or data phase must not be taken
	sequence wr_take;
		s_axi_lite_awvalid && s_axi_lite_wvalid && !awr && !bv && en;
	endsequence
	sequence rd_take;
		s_axi_lite_arvalid && !arr && !rv && en;
	endsequence
	chk_write_accept: assert property (wr_take |=> awr)
		else $error("write not accepted");
	chk_write_resp: assert property (wr_take ##1 en |=> bv && !awr)
		else $error("write response late");
	chk_ready_pair: assert property (awr == s_axi_lite_wready)
		else $error("write readies differ");
	chk_read_accept: assert property (rd_take |=> arr)
		else $error("read not accepted");
	chk_read_resp: assert property (rd_take ##1 en |=> rv && !arr)
		else $error("read data late");
	chk_resp_code: assert property (bv || rv |->
		s_axi_lite_bresp == GCR_RESP_OKAY && s_axi_lite_rresp == GCR_RESP_OKAY)
		else $error("response code not okay");
	chk_bresp_hold: assert property (bv && !s_axi_lite_bready |=> bv)
		else $error("write response dropped");
	chk_rdata_hold: assert property (rv && !s_axi_lite_rready |=> rv)
		else $error("read data dropped");
	chk_gate_freeze: assert property (!en |=> $stable({awr, bv, arr, rv}))
		else $error("outputs moved while halted");
endmodule : gcr_properties

bind gcr_regbank gcr_properties i_props (.*);

//--- test/gcr_axi_master.sv
`timescale 1ns/100ps
module gcr_axi_master (
	input wire logic core_clk,
	input wire logic core_clock_gate,
	input wire logic s_axi_lite_awready,
	input wire logic s_axi_lite_bvalid,
	input wire logic s_axi_lite_arready,
	input wire logic s_axi_lite_rvalid,
	output logic s_axi_lite_awvalid = 1'b0,
	output logic s_axi_lite_wvalid = 1'b0,
	output logic s_axi_lite_bready = 1'b0,
	output logic s_axi_lite_arvalid = 1'b0,
	output logic s_axi_lite_rready = 1'b0,
	output logic [31:0] s_axi_lite_awaddr = '0,
	output logic [31:0] s_axi_lite_wdata = '0,
	output logic [31:0] s_axi_lite_araddr = '0
);
	int n;
	// a handshake only counts on an edge where the core is not halted
	task hold_edge;
		@(posedge core_clk);
		while (!core_clock_gate)
			@(posedge core_clk);
		@(negedge core_clk);
	endtask : hold_edge
	// waits are bounded: a silent slave costs time, the bench sees the loss
	task wr(input logic [31:0] a, d);
		@(negedge core_clk);
		s_axi_lite_awaddr = a;
		s_axi_lite_wdata = d;
		{s_axi_lite_awvalid, s_axi_lite_wvalid} = 2'h3;
		for (n = 0; n < 50 && !s_axi_lite_awready; n++)
			@(negedge core_clk);
		hold_edge();
		{s_axi_lite_awvalid, s_axi_lite_wvalid} = 2'h0;
		s_axi_lite_awaddr = ~a;
		s_axi_lite_wdata = ~d;
		repeat ($urandom_range(2)) @(negedge core_clk);
		s_axi_lite_bready = 1'b1;
		for (n = 0; n < 50 && !s_axi_lite_bvalid; n++)
			@(negedge core_clk);
		hold_edge();
		s_axi_lite_bready = 1'b0;
	endtask : wr
	task rd(input logic [31:0] a);
		@(negedge core_clk);
		s_axi_lite_araddr = a;
		s_axi_lite_arvalid = 1'b1;
		for (n = 0; n < 50 && !s_axi_lite_arready; n++)
			@(negedge core_clk);
		hold_edge();
		s_axi_lite_arvalid = 1'b0;
		s_axi_lite_araddr = ~a;
		repeat ($urandom_range(2)) @(negedge core_clk);
		s_axi_lite_rready = 1'b1;
		for (n = 0; n < 50 && !s_axi_lite_rvalid; n++)
			@(negedge core_clk);
		hold_edge();
		s_axi_lite_rready = 1'b0;
	endtask : rd
endmodule : gcr_axi_master

//--- test/gamma_control_register_bank_tb.sv
`timescale 1ns/100ps
module gamma_control_register_bank_tb
	import gcr_pkg::*;
;
	localparam logic [31:0] DIMR = 32'h0002_0003;
	// arbitrary value, not tied to any real part
	localparam logic [31:0] VER = 32'h0a0b_0c0d;
	logic core_clk = 1'b0, sys_rst = 1'b1, core_clock_gate = 1'b1;
	logic s_axi_lite_awvalid, s_axi_lite_wvalid, s_axi_lite_bready;
	logic s_axi_lite_arvalid, s_axi_lite_rready, s_axi_lite_awready;
	logic [31:0] s_axi_lite_awaddr, s_axi_lite_wdata, s_axi_lite_araddr;
	logic s_axi_lite_wready, s_axi_lite_bvalid, s_axi_lite_arready;
	logic s_axi_lite_rvalid, core_run, bypass_on, pattern_on, core_reset, irq;
	logic [1:0] s_axi_lite_bresp, s_axi_lite_rresp;
	logic [31:0] s_axi_lite_rdata, active_dims, active_swap, m, r;
	logic [31:0] rq[$], lq[$];
	gcr_strm_t strm = '0;
	gcr_lutwr_t lut_wr;
	int num_errors = 0, checked = 0;
	always #4 core_clk = ~core_clk;
	gcr_regbank #(.DIM_RESET(DIMR), .VERSION_ID(VER)) i_dut (.*);
	gcr_axi_master i_mst (.*);
	task chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task complete_run;
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task rd(input logic [31:0] a, e);
		rq.push_back(e);
		i_mst.rd(a);
	endtask : rd
	task tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	// pixels go back to back, the hardest spacing for the line tracker
	task ln(input int n, input logic s);
		for (int i = 0; i < n; i++) begin
			strm = {1'b1, s && i == 0, i == n - 1};
			@(negedge core_clk);
		end
		strm = '0;
	endtask : ln
	always @(posedge core_clk) begin
		if (s_axi_lite_rvalid && s_axi_lite_rready && rq.size() > 0)
			chk("rdata", rq.pop_front(), s_axi_lite_rdata);
		if (lut_wr.wr === 1'b1 && lq.size() > 0)
			chk("lut_wr", lq.pop_front(), {lut_wr.addr, lut_wr.data});
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h0d1c));
		tick(10);
		sys_rst = 1'b0;
		tick(1);
		chk("dims", DIMR, active_dims);
		for (int a = 0; a <= 'h24; a += 4)
			rd(32'(a), a == 'h10 ? VER : a == 'h20 ? DIMR : 32'h0);
		rd(GCR_OFS_SWAP, 0);
		wr(GCR_OFS_DIMS, 32'h0003_0002);
		wr(GCR_OFS_SWAP, 32'h0000_0005);
		wr(GCR_OFS_CTRL, 32'h0000_0033);
		rd(GCR_OFS_CTRL, 32'h0000_0033);
		chk("modes", 3'h7, {core_run, bypass_on, pattern_on});
		chk("dims", DIMR, active_dims);
		r = $urandom;
		lq.push_back(r);
		wr(GCR_OFS_LUTWR, r);
		wr(32'h0000_0044, 32'hffff_ffff);
		rd(32'h0000_0044, 0);
		ln(3, 1);
		ln(3, 0);
		tick(1);
		chk("dims", 32'h0003_0002, active_dims);
		chk("swap", 5, active_swap);
		rd(GCR_OFS_STATUS, 3);
		rd(GCR_OFS_FRAMES, 1);
		rd(GCR_OFS_LINES, 2);
		rd(GCR_OFS_PIXELS, 6);
		m = ($urandom & 32'h0001_fffe) | 32'h2;
		wr(GCR_OFS_MASK, m);
		rd(GCR_OFS_MASK, m);
		chk("irq", 1, irq);
		wr(GCR_OFS_STATUS, 1);
		rd(GCR_OFS_STATUS, 2);
		wr(GCR_OFS_STATUS, 2);
		tick(2);
		chk("irq", 0, irq);
		ln(1, 1);
		ln(3, 0);
		ln(1, 1);
		rd(GCR_OFS_ERROR, 7);
		rd(GCR_OFS_STATUS, 32'h0001_0001);
		chk("irq", 32'(m[16]), irq);
		wr(GCR_OFS_ERROR, 1);
		rd(GCR_OFS_ERROR, 6);
		wr(GCR_OFS_ERROR, 6);
		ln(2, 0);
		ln(2, 0);
		wr(GCR_OFS_STATUS, 32'h0001_0003);
		wr(GCR_OFS_CTRL, 32'h4000_0001);
		rd(GCR_OFS_CTRL, 1);
		rd(GCR_OFS_FRAMES, 0);
		wr(GCR_OFS_CTRL, 0);
		ln(2, 1);
		rd(GCR_OFS_STATUS, 0);
		wr(GCR_OFS_CTRL, 32'h8000_0000);
		chk("core_reset", 1, core_reset);
		wr(GCR_OFS_CTRL, 0);
		tick(2);
		chk("core_reset", 0, core_reset);
		fork
			rd(GCR_OFS_MASK, m);
			begin
				tick(1);
				core_clock_gate = 1'b0;
				tick(3);
				core_clock_gate = 1'b1;
			end
		join
		chk("pending", 0, 32'(rq.size() + lq.size()));
		complete_run();
	end
	task wr(input logic [31:0] a, d);
		i_mst.wr(a, d);
	endtask : wr
endmodule : gamma_control_register_bank_tb
